// [hw/nsmc_top.sv]
// Purpose: Security engagement, mode selection, configuration byte update and
//    bootstrap clearing for the on-chip nonvolatile memory.
// Assumes: All inputs synchronous to clock_i; memory engines answer on mem_done_i.
// Notes: Security and mode are evaluated every cycle while rst_b_i is low.
`timescale 1ns/1ps
module nsmc_top #(
   parameter int unsigned PROG_DELAY_CYCLES = nsmc_pkg::PROG_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic mask_secure_cap_i,
   input wire logic [nsmc_pkg::CTL_W-1:0] config_nv_i,
   input wire logic mode_select_a_pin_i,
   input wire logic mode_select_b_pin_i,
   input wire logic strobe_in_or_addr_strobe_pin_i,
   input wire logic addr_strobe_i,
   input wire logic ctl_wr_i,
   input wire logic [nsmc_pkg::CTL_W-1:0] ctl_wdata_i,
   input wire logic nvm_wr_i,
   input wire logic nvm_wr_config_i,
   input wire logic [nsmc_pkg::CTL_W-1:0] nvm_wdata_i,
   input wire logic mem_done_i,
   input wire logic mem_verify_ok_i,
   output logic [nsmc_pkg::CTL_W-1:0] nvm_program_control_o,
   output logic [nsmc_pkg::CTL_W-1:0] config_o,
   output logic config_update_o,
   output logic secure_o,
   output nsmc_pkg::nsmc_mode_t op_mode_o,
   output logic ext_bus_drive_o,
   output logic strobe_in_or_addr_strobe_pin_o,
   output logic strobe_in_or_addr_strobe_pin_oe_o,
   output logic strobe_a_o,
   output logic ee_read_enable_o,
   output logic rom_access_o,
   output logic ee_bulk_erase_o,
   output logic ram_fill_o,
   output logic [nsmc_pkg::CTL_W-1:0] ram_fill_data_o,
   output logic mem_verify_o,
   output logic download_start_o
);
   import nsmc_pkg::*;

   logic [CTL_W-1:0] ctl_r;
   logic [CTL_W-1:0] config_r;
   logic [CTL_W-1:0] data_r;
   logic armed_r;
   logic tgt_cfg_r;
   logic secure_r;
   nsmc_mode_t mode_r;
   logic cfg_upd_r;
   logic ext_r;
   logic pin_do_r;
   logic pin_oe_r;
   logic stra_r;
   logic rom_r;
   logic bulk_r;
   logic fill_r;
   logic verify_r;
   logic dl_r;
   logic [CTL_W-1:0] fill_data_r;
   logic rde_r;
   nsmc_seq_e seq_r;
   nsmc_seq_e seq_nxt;
   logic timer_done;

   // Security capability and mode evaluation, used while in reset.
   wire secure_eval = mask_secure_cap_i && !config_nv_i[SEC_DISABLE_BIT];
   wire mode_a_eff = mode_select_a_pin_i && !secure_eval;
   wire nsmc_mode_t mode_eval = {mode_select_b_pin_i, mode_a_eff};
   wire expanded = (mode_r == MODE_EXPANDED);

   // Program control write decode.
   wire pgm_req = ctl_wdata_i[CTL_PGM_BIT] && ctl_r[CTL_LAT_BIT];
   wire [CTL_W-1:0] ctl_nxt = {ctl_wdata_i[CTL_W-1:CTL_ZERO_BIT+1], 1'b0,
      ctl_wdata_i[CTL_BYTE_BIT:CTL_LAT_BIT], pgm_req};
   wire timer_start = ctl_wr_i && pgm_req && !ctl_r[CTL_PGM_BIT];
   wire timer_abort = ctl_wr_i && !pgm_req;
   wire capture = nvm_wr_i && ctl_r[CTL_LAT_BIT] && !ctl_r[CTL_PGM_BIT];

   // Operation applied when the high-voltage period completes.
   wire op_done = timer_done && armed_r && ctl_r[CTL_PGM_BIT];
   wire erase_sel = ctl_r[CTL_ERASE_BIT];
   wire bulk_sel = erase_sel && !ctl_r[CTL_BYTE_BIT] && !ctl_r[CTL_ROW_BIT];
   wire cpu_bulk = op_done && bulk_sel;
   wire cfg_erase = cpu_bulk && tgt_cfg_r;
   wire cfg_prog = op_done && !erase_sel && tgt_cfg_r;
   wire unlock = (seq_r == SQ_UNLOCK);

   wire [CTL_W-1:0] config_nxt = (cfg_erase || unlock) ? CFG_ERASED :
      cfg_prog ? (config_r & data_r) : config_r;

   // Bootstrap clearing sequencer; the exit from reset in bootstrap starts it.
   always_comb
   begin
      seq_nxt = seq_r;
      case (seq_r)
         SQ_IDLE:
            if (mode_r == MODE_BOOT)
               seq_nxt = secure_r ? SQ_ERASE : SQ_DOWNLOAD;
         SQ_ERASE:
            if (mem_done_i)
               seq_nxt = SQ_FILL;
         SQ_FILL:
            if (mem_done_i)
               seq_nxt = SQ_VERIFY;
         SQ_VERIFY:
            if (mem_done_i)
               seq_nxt = mem_verify_ok_i ? SQ_UNLOCK : SQ_ERASE;
         SQ_UNLOCK:
            seq_nxt = SQ_DOWNLOAD;
         SQ_DOWNLOAD:
            seq_nxt = SQ_DOWNLOAD;
         default:
            seq_nxt = SQ_IDLE;
      endcase
   end

   wire enter_erase = (seq_nxt == SQ_ERASE) && (seq_r != SQ_ERASE);
   wire enter_fill = (seq_nxt == SQ_FILL) && (seq_r != SQ_FILL);
   wire enter_verify = (seq_nxt == SQ_VERIFY) && (seq_r != SQ_VERIFY);
   wire enter_dl = (seq_nxt == SQ_DOWNLOAD) && (seq_r != SQ_DOWNLOAD);

   nsmc_delay #(
      .CYCLES(PROG_DELAY_CYCLES)
   ) u_delay (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .start_i(timer_start),
      .abort_i(timer_abort),
      .done_o(timer_done)
   );

   // While in reset, security and mode follow the pins and the stored byte.
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         config_r <= config_nv_i;
         secure_r <= secure_eval;
         mode_r <= mode_eval;
      end
      else
      begin
         config_r <= config_nxt;
         if (unlock)
            secure_r <= 1'b0;
      end
   end

   // Program control register and captured address and data.
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         ctl_r <= CTL_RESET;
         armed_r <= 1'b0;
         tgt_cfg_r <= 1'b0;
         data_r <= CFG_ERASED;
         cfg_upd_r <= 1'b0;
         rde_r <= 1'b1;
      end
      else
      begin
         cfg_upd_r <= (config_nxt != config_r);
         if (ctl_wr_i)
         begin
            ctl_r <= ctl_nxt;
            // Read enable tracks the latch bit being stored, so it moves with ctl_r.
            rde_r <= !ctl_wdata_i[CTL_LAT_BIT];
         end
         if (ctl_wr_i && !ctl_wdata_i[CTL_LAT_BIT])
            armed_r <= 1'b0;
         else if (capture)
         begin
            armed_r <= 1'b1;
            tgt_cfg_r <= nvm_wr_config_i;
            data_r <= nvm_wdata_i;
         end
      end
   end

   // Pin and bus visibility; the strobe pin is also steered during reset.
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         ext_r <= 1'b0;
         pin_do_r <= 1'b0;
         pin_oe_r <= (mode_eval == MODE_EXPANDED);
         stra_r <= 1'b0;
         rom_r <= 1'b0;
      end
      else
      begin
         ext_r <= expanded;
         pin_do_r <= addr_strobe_i && expanded;
         pin_oe_r <= expanded;
         stra_r <= strobe_in_or_addr_strobe_pin_i && !expanded;
         rom_r <= 1'b1;
      end
   end

   // Memory clearing requests, one-cycle pulses.
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         seq_r <= SQ_IDLE;
         bulk_r <= 1'b0;
         fill_r <= 1'b0;
         verify_r <= 1'b0;
         dl_r <= 1'b0;
         fill_data_r <= RAM_FILL_VALUE;
      end
      else
      begin
         seq_r <= seq_nxt;
         bulk_r <= enter_erase || cpu_bulk;
         fill_r <= enter_fill;
         verify_r <= enter_verify;
         dl_r <= enter_dl;
         fill_data_r <= RAM_FILL_VALUE;
      end
   end

   assign nvm_program_control_o = ctl_r;
   assign config_o = config_r;
   assign config_update_o = cfg_upd_r;
   assign secure_o = secure_r;
   assign op_mode_o = mode_r;
   assign ext_bus_drive_o = ext_r;
   assign strobe_in_or_addr_strobe_pin_o = pin_do_r;
   assign strobe_in_or_addr_strobe_pin_oe_o = pin_oe_r;
   assign strobe_a_o = stra_r;
   // EEPROM reads are blocked only by the program latch, never by security.
   assign ee_read_enable_o = rde_r;
   assign rom_access_o = rom_r;
   assign ee_bulk_erase_o = bulk_r;
   assign ram_fill_o = fill_r;
   assign ram_fill_data_o = fill_data_r;
   assign mem_verify_o = verify_r;
   assign download_start_o = dl_r;

endmodule : nsmc_top

// [hw/nsmc_pkg.sv]
// Purpose: Shared constants for the nonvolatile security and mode control block.
// Assumes: 100 MHz core clock, 8-bit program control and configuration bytes.
// Notes: Mode codes are {mode_select_b_pin, mode_select_a_pin} after security masking.
package nsmc_pkg;

   localparam int CTL_W = 8;

   // Program control field positions.
   localparam int CTL_PGM_BIT = 0;
   localparam int CTL_LAT_BIT = 1;
   localparam int CTL_ERASE_BIT = 2;
   localparam int CTL_ROW_BIT = 3;
   localparam int CTL_BYTE_BIT = 4;
   localparam int CTL_ZERO_BIT = 5;
   localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;

   // Configuration byte layout and values.
   localparam int SEC_DISABLE_BIT = 3;
   localparam logic [CTL_W-1:0] CFG_ERASED = 8'hFF;
   localparam logic [CTL_W-1:0] RAM_FILL_VALUE = 8'hFF;

   // Operating modes.
   typedef logic [1:0] nsmc_mode_t;
   localparam nsmc_mode_t MODE_BOOT = 2'h0;
   localparam nsmc_mode_t MODE_TEST = 2'h1;
   localparam nsmc_mode_t MODE_SINGLE = 2'h2;
   localparam nsmc_mode_t MODE_EXPANDED = 2'h3;

   // Program and erase high-voltage time.
   localparam int PROG_TIME_US = 10000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int DLY_W = 20;

   // Bootstrap clearing sequencer.
   typedef enum logic [5:0] {
      SQ_IDLE = 6'h01,
      SQ_ERASE = 6'h02,
      SQ_FILL = 6'h04,
      SQ_VERIFY = 6'h08,
      SQ_UNLOCK = 6'h10,
      SQ_DOWNLOAD = 6'h20
   } nsmc_seq_e;

endpackage : nsmc_pkg

// [hw/nsmc_delay.sv]
// Purpose: One-shot cycle timer for the program and erase high-voltage period.
// Assumes: start_i and abort_i are one-cycle pulses; abort wins over a running count.
// Notes: done_o is a one-cycle pulse CYCLES clock edges after start.
`timescale 1ns/1ps
module nsmc_delay #(
   parameter int unsigned CYCLES = 1000000
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic abort_i,
   output logic done_o
);
   import nsmc_pkg::*;

   localparam logic [DLY_W-1:0] LOAD = DLY_W'(CYCLES - 1);

   logic [DLY_W-1:0] count_r;
   logic running_r;
   logic done_r;

   wire expire = running_r && (count_r == '0) && !abort_i;

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         count_r <= '0;
         running_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= expire;
         if (abort_i || expire)
            running_r <= 1'b0;
         else if (start_i)
         begin
            running_r <= 1'b1;
            count_r <= LOAD;
         end
         else if (running_r)
            count_r <= count_r - 1'b1;
      end
   end

   assign done_o = done_r;

endmodule : nsmc_delay

// [verif/nsmc_props.sv]
// Purpose: Port-level checks for the security and mode control block.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes: Reset-time checks run without a disable condition on purpose.
`timescale 1ns/1ps
module nsmc_props
   import nsmc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic mask_secure_cap_i,
   input wire logic [CTL_W-1:0] config_nv_i,
   input wire logic mode_select_a_pin_i,
   input wire logic mode_select_b_pin_i,
   input wire logic ctl_wr_i,
   input wire logic [CTL_W-1:0] ctl_wdata_i,
   input wire logic mem_done_i,
   input wire logic mem_verify_ok_i,
   input wire logic [CTL_W-1:0] nvm_program_control_o,
   input wire logic secure_o,
   input wire nsmc_mode_t op_mode_o,
   input wire logic ext_bus_drive_o,
   input wire logic strobe_in_or_addr_strobe_pin_oe_o,
   input wire logic rom_access_o,
   input wire logic ee_read_enable_o,
   input wire logic ee_bulk_erase_o,
   input wire logic download_start_o
);
   logic sec_eval;
   logic unlock_ok;
   assign sec_eval = mask_secure_cap_i & ~config_nv_i[SEC_DISABLE_BIT];
   assign unlock_ok = mem_done_i & mem_verify_ok_i;
   default clocking @(posedge clock_i); endclocking
   chk_sec_eval: assert property (!rst_b_i |=> secure_o == $past(sec_eval))
      else $error("security state not taken in reset");
   chk_mode_mask: assert property (!rst_b_i |=> op_mode_o ==
      {$past(mode_select_b_pin_i), $past(mode_select_a_pin_i & ~sec_eval)})
      else $error("mode latch wrong");
   chk_no_expand: assert property (disable iff (!rst_b_i)
      secure_o |-> op_mode_o != MODE_EXPANDED) else $error("secured part expanded");
   chk_bus_hidden: assert property (disable iff (!rst_b_i)
      op_mode_o != MODE_EXPANDED |=> !ext_bus_drive_o) else $error("bus driven");
   chk_strobe_hiz: assert property (op_mode_o != MODE_EXPANDED
      |-> !strobe_in_or_addr_strobe_pin_oe_o) else $error("strobe pin driven");
   chk_rom_open: assert property (disable iff (!rst_b_i)
      $past(rst_b_i) |-> rom_access_o) else $error("rom closed");
   chk_pgm_lock: assert property (disable iff (!rst_b_i) ctl_wr_i &&
      ctl_wdata_i[CTL_PGM_BIT] && !nvm_program_control_o[CTL_LAT_BIT]
      |=> !nvm_program_control_o[CTL_PGM_BIT]) else $error("voltage set unlatched");
   chk_unlock_order: assert property (disable iff (!rst_b_i)
      $fell(secure_o) |-> $past(unlock_ok) || $past(unlock_ok, 2))
      else $error("unlock without verify");
   chk_dl_clear: assert property (disable iff (!rst_b_i)
      download_start_o |-> !secure_o) else $error("download while secured");
   chk_boot_erase: assert property (disable iff (!rst_b_i) !$past(rst_b_i) &&
      secure_o && op_mode_o == MODE_BOOT |-> ##[0:2] ee_bulk_erase_o)
      else $error("no boot erase");
   chk_secure_read: assert property (disable iff (!rst_b_i) secure_o &&
      !nvm_program_control_o[CTL_LAT_BIT] |-> ee_read_enable_o)
      else $error("secured part blocks eeprom reads");
endmodule : nsmc_props
bind nsmc_top nsmc_props chk (.clock_i, .rst_b_i, .mask_secure_cap_i, .config_nv_i,
   .mode_select_a_pin_i, .mode_select_b_pin_i, .ctl_wr_i, .ctl_wdata_i, .mem_done_i,
   .mem_verify_ok_i, .nvm_program_control_o, .secure_o, .op_mode_o, .ext_bus_drive_o,
   .strobe_in_or_addr_strobe_pin_oe_o, .rom_access_o, .ee_read_enable_o, .ee_bulk_erase_o,
   .download_start_o);

// [verif/nsmc_mem_model.sv]
// Purpose: Memory engine that answers erase, fill and verify requests.
// Assumes: Requests are one-cycle pulses; latency set by lat_i.
// Notes: Verify fails fails_i times per reset; ok toggles outside done.
`timescale 1ns/1ps
module nsmc_mem_model (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic req_i,
   input wire logic verify_i,
   input wire logic [3:0] lat_i,
   input wire logic [3:0] fails_i,
   output logic done_o,
   output logic ok_o
);
   logic [3:0] cnt_r;
   logic [3:0] bad_r;
   logic busy_r;
   logic ver_r;
   always_ff @(posedge clock_i)
   begin
      done_o <= 1'b0;
      ok_o <= ~ok_o;
      if (!rst_b_i)
      begin
         busy_r <= 1'b0;
         bad_r <= 4'h0;
         ok_o <= 1'b0;
      end
      else if (req_i)
      begin
         busy_r <= 1'b1;
         cnt_r <= lat_i;
         ver_r <= verify_i;
      end
      else if (busy_r && cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
      else if (busy_r)
      begin
         busy_r <= 1'b0;
         done_o <= 1'b1;
         ok_o <= ~ver_r | (bad_r >= fails_i);
         if (ver_r && bad_r < fails_i)
            bad_r <= bad_r + 4'h1;
      end
   end
endmodule : nsmc_mem_model

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the security and mode control block.
// Assumes: Program delay shortened to 20 cycles.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module tb_top;
   import nsmc_pkg::*;
   logic clock_i = 0, rst_b_i = 0, mask = 0, mda = 0, mdb = 1, pin = 0, as_i = 1;
   logic cw = 0, nw = 0, done, ok, sec, cup, ext, po, poe, sa, rde, rom, ber, rf, mv, dl;
   logic tgt = 1;
   logic [7:0] cfg = 8'hFF, cwd = 8'h00, nwd = 8'h00, ctl, cfo, rfd;
   logic [3:0] fails = 4'h0, lat = 4'h0;
   nsmc_mode_t md;
   int fail_count = 0, cmp_count = 0;
   nsmc_top #(.PROG_DELAY_CYCLES(20)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .mask_secure_cap_i(mask), .config_nv_i(cfg), .mode_select_a_pin_i(mda),
      .mode_select_b_pin_i(mdb), .strobe_in_or_addr_strobe_pin_i(pin),
      .addr_strobe_i(as_i), .ctl_wr_i(cw), .ctl_wdata_i(cwd), .nvm_wr_i(nw),
      .nvm_wr_config_i(tgt), .nvm_wdata_i(nwd), .mem_done_i(done), .mem_verify_ok_i(ok),
      .nvm_program_control_o(ctl), .config_o(cfo), .config_update_o(cup), .secure_o(sec),
      .op_mode_o(md), .ext_bus_drive_o(ext), .strobe_in_or_addr_strobe_pin_o(po),
      .strobe_in_or_addr_strobe_pin_oe_o(poe), .strobe_a_o(sa), .ee_read_enable_o(rde),
      .rom_access_o(rom), .ee_bulk_erase_o(ber), .ram_fill_o(rf), .ram_fill_data_o(rfd),
      .mem_verify_o(mv), .download_start_o(dl));
   nsmc_mem_model mem (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(ber | rf | mv),
      .verify_i(mv), .lat_i(lat), .fails_i(fails), .done_o(done), .ok_o(ok));
   initial forever #5 clock_i = ~clock_i;
   task cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc
   task chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
         begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task rst(input logic m, input logic [7:0] c, input logic a, input logic b);
      rst_b_i = 0;
      mask = m;
      cfg = c;
      mda = a;
      mdb = b;
      cyc(3);
   endtask : rst
   task wr_ctl(input logic [7:0] d);
      cw = 1;
      cwd = d;
      cyc(1);
      cw = 0;
      cyc(1);
   endtask : wr_ctl
   task op(input logic [7:0] s, input logic [7:0] d, output int nb, output int nu);
      wr_ctl(s);
      nw = 1;
      nwd = d;
      cyc(1);
      nw = 0;
      wr_ctl(s | 8'h01);
      nb = 0;
      nu = 0;
      repeat (30)
      begin
         cyc(1);
         nb += ber;
         nu += cup;
      end
   endtask : op
   task t_modes;
      logic [1:0] em;
      logic es;
      for (int i = 0; i < 16; i++)
      begin
         rst(i[3], i[2] ? 8'hFF : 8'hF7, i[0], i[1]);
         es = i[3] & ~i[2];
         em = {i[1], i[0] & ~es};
         chk(sec, es);
         chk(md, em);
         chk(poe, em == 2'h3);
         // With mode B low the probe stays in reset, or the part would boot and unlock.
         rst_b_i = i[1];
         cyc(3);
         chk(sec, es);
         chk(ext, em == 2'h3);
         chk(rom, i[1]);
         if (em == 2'h3)
            chk(po, as_i);
      end
      $display("t_modes done");
   endtask : t_modes
   task t_nvm;
      int nb;
      int nu;
      // A secured part in single-chip mode, so internal access is judged while secured.
      rst(1, 8'hF7, 0, 1);
      rst_b_i = 1;
      pin = 1;
      cyc(3);
      chk(sec, 1);
      chk(sa, 1);
      chk(rde, 1);
      wr_ctl(8'h01);
      chk(ctl, 8'h00);
      op(8'h06, 8'h00, nb, nu);
      chk(cfo, 8'hFF);
      chk(nb, 1);
      chk(nu, 1);
      chk(rde, 0);
      op(8'h02, 8'h5A, nb, nu);
      chk(cfo, 8'h5A);
      chk(nu, 1);
      op(8'h02, 8'h0A, nb, nu);
      chk(cfo, 8'h0A);
      chk(nu, 1);
      op(8'h16, 8'h00, nb, nu);
      chk(nb, 0);
      op(8'h0E, 8'h00, nb, nu);
      chk(nb, 0);
      chk(nu, 0);
      chk(cfo, 8'h0A);
      tgt = 0;
      op(8'h06, 8'h00, nb, nu);
      tgt = 1;
      chk(nb, 1);
      chk(cfo, 8'h0A);
      wr_ctl(8'h00);
      chk(ctl, 8'h00);
      chk(rde, 1);
      $display("t_nvm done");
   endtask : t_nvm
   task t_boot(input logic m, input logic [3:0] f, input logic [3:0] l);
      int ne;
      int nf;
      int nv;
      int n;
      rst(m, 8'hF7, 0, 0);
      fails = f;
      lat = l;
      rst_b_i = 1;
      ne = 0;
      nf = 0;
      nv = 0;
      n = 0;
      while (dl !== 1'b1 && n < 300)
      begin
         cyc(1);
         ne += ber;
         nf += rf;
         nv += mv;
         n++;
      end
      chk(nf, m ? f + 1 : 0);
      chk(nv, m ? f + 1 : 0);
      chk(dl, 1);
      chk(sec, 0);
      chk(cfo, m ? 8'hFF : 8'hF7);
      chk(ne, m ? f + 1 : 0);
      chk(rfd, 8'hFF);
      $display("t_boot done");
   endtask : t_boot
   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial
   begin
      #200us;
      fail_count++;
      wrap_up;
   end
   initial
   begin
      rst(0, 8'hFF, 0, 1);
      cyc(17);
      t_modes;
      t_nvm;
      t_boot(1, 4'h2, 4'h3);
      t_boot(1, 4'h0, 4'h0);
      t_boot(0, 4'h0, 4'h1);
      wrap_up;
   end
endmodule : tb_top
